// ### pin_function_map.vh
`ifndef PIN_FUNCTION_MAP_VH
`define PIN_FUNCTION_MAP_VH

// Lane width modes reported by the command decoder.
`define WIDTH_SINGLE 2'h0
`define WIDTH_DUAL   2'h1
`define WIDTH_QUAD   2'h2

// Minimum reset pulse time in nanoseconds and core clock period.
`define RESET_PULSE_NS 200
`define CORE_CLK_NS    10
// Least time rounds up to whole cycles.
`define RESET_PULSE_CYCLES ((`RESET_PULSE_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

// Deselect time during which lane 3 is driven high after a read.
`define DESELECT_NS     20
`define DESELECT_CYCLES (`DESELECT_NS / `CORE_CLK_NS)

// Synchroniser depth for pin inputs.
`define SYNC_STAGES 3

`endif

// ### pin_sync.v
`timescale 1ns/100ps
`default_nettype none

// Three-stage pin synchroniser; the output changes only once the
// second and third stages agree, which rejects single-cycle glitches.
module pin_sync #(
    parameter RESET_VALUE = 1'b1
) (
    input  wire core_clk,
    input  wire rst,
    input  wire pin,
    output reg  level
);

    reg [2:0] stage_r; // Stage 0 feeds only stage 1.

    // Shift chain and agreement filter.
    always @(posedge core_clk) begin
        if (rst) begin
            stage_r <= {3{RESET_VALUE}};
            level   <= RESET_VALUE;
        end else begin
            stage_r <= {stage_r[1:0], pin};
            // Accept a change only when stages 1 and 2 match.
            if (stage_r[1] == stage_r[2]) begin
                level <= stage_r[2];
            end
        end
    end

endmodule // pin_sync

`default_nettype wire

// ### pin_function_select.v
`timescale 1ns/100ps
`default_nettype none
`include "pin_function_map.vh"

// Summary of operation
// - Lane 0 input single, bidirectional dual/quad.
// - Lane 1 output single, bidirectional dual/quad.
// - Quad off, disable bit set: lane 2 write-protect.
// - Quad on: lane 2 data, protection off.
// - Quad on, select low: lane 3 data.
// - Reset enabled, quad off: lane 3 reset.
// - Reset enabled, quad on: reset only deselected.
// - Protected status writes ignored, no error.
// - Reset needs select high, low for pulse time.
// - Host drives lane 3 high; device after reads.
// - Reset disabled: lane 3 ignored for reset.
module pin_function_select #(
    parameter RESET_PULSE_CYCLES = `RESET_PULSE_CYCLES,
    parameter DESELECT_CYCLES    = `DESELECT_CYCLES
) (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       quad_enable_bit,          // Quad mode enable.
    input  wire       status_write_disable_bit, // Status write disable.
    input  wire       reset_pin_enable_bit,     // Lane 3 reset enable.
    input  wire [1:0] cmd_width,                // Width of current command.
    input  wire       read_transfer,            // Current command returns data.
    input  wire       status_register_write_cmd,// Decoded status write command.
    input  wire       any_register_write_cmd,   // Decoded any-register write.
    input  wire       write_targets_protected,  // Target is status 1 or config 1.
    input  wire       cs_n_pin,                 // Chip select pin, active low.
    input  wire       sclk_pin,                 // Serial clock pin.
    input  wire [3:0] lane_in,                  // Pin input levels.
    input  wire [3:0] core_lane_out,            // Data the core wants to send.
    input  wire [3:0] core_lane_drive,          // Lanes the core wants to drive.
    output reg  [3:0] lane_out,                 // Pin output levels.
    output reg  [3:0] lane_oe,                  // Pin output enables, high drives.
    output reg  [3:0] lane_rx,                  // Synchronised input data.
    output reg        serial_in_bit,            // Single-bit serial input.
    output reg        write_protect_n,          // Sensed write-protect, low protects.
    output reg        write_accept,             // Register write permitted.
    output reg        write_ignored,            // Pulse: protected write dropped.
    output reg        hw_reset,                 // Pulse: hardware reset detected.
    output wire       sclk_rise,                // Pulse: serial clock rising edge.
    output wire       cs_n_level                // Synchronised chip select.
);

    // Internal state; every register below resets synchronously with rst.
    wire [3:0] lane_sync;  // Synchronised lane levels.
    wire       cs_sync;    // Synchronised chip select.
    wire       sclk_sync;  // Synchronised serial clock.
    reg        sclk_r;     // Previous serial clock level.
    reg        cs_r;       // Previous chip select level.
    reg        was_read_r; // Last selected transfer returned data.
    reg [15:0] rp_cnt_r;   // Reset low duration counter.
    reg [15:0] ds_cnt_r;   // Deselect drive counter.
    reg        wr_cmd_r;   // Previous write command level.

    // One synchroniser per lane; pull-ups make high the safe reset value.
    // Lanes and select share one depth, so a lane and the select that moves
    // with it reach the logic on the same edge and no false reset is seen.
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            pin_sync #(.RESET_VALUE(1'b1)) u_sync (
                .core_clk (core_clk),
                .rst      (rst),
                .pin      (lane_in[i]),
                .level    (lane_sync[i])
            );
        end
    endgenerate

    // Chip select resets to its deselected level.
    pin_sync #(.RESET_VALUE(1'b1)) u_cs (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (cs_n_pin),
        .level    (cs_sync)
    );

    // The serial clock idles low between frames, so it resets low.
    pin_sync #(.RESET_VALUE(1'b0)) u_sck (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (sclk_pin),
        .level    (sclk_sync)
    );

    // The edge history resets to the idle low of the clock pin, so no false
    // rising edge follows reset.
    assign cs_n_level = cs_sync;
    assign sclk_rise  = sclk_sync & ~sclk_r;

    // Lane 2 is write-protect only when quad is off.
    function wp_active;
        input quad;
        input swd;
        begin
            wp_active = ~quad & swd;
        end
    endfunction

    // Lane 3 is a reset input under enable, and quad off or deselected.
    function rst_role;
        input en;
        input quad;
        input cs_n;
        begin
            rst_role = en & (~quad | cs_n);
        end
    endfunction

    // Lane roles and output enables.
    always @* begin
        lane_oe  = 4'h0;
        lane_out = core_lane_out;
        if (!cs_sync) begin
            if (cmd_width == `WIDTH_SINGLE) begin
                // Only the serial output lane may drive.
                lane_oe[1] = core_lane_drive[1];
            end else begin
                // Dual and quad commands turn lanes 0 and 1 around.
                lane_oe[1:0] = core_lane_drive[1:0];
                // Lanes 2 and 3 carry data only with quad enabled.
                if (quad_enable_bit && cmd_width == `WIDTH_QUAD) begin
                    lane_oe[3:2] = core_lane_drive[3:2];
                end
            end
        end else if (ds_cnt_r != 16'h0000) begin
            // Hold lane 3 high after reads so no false reset is seen.
            lane_oe[3]  = 1'b1;
            lane_out[3] = 1'b1;
        end
    end

    // Registered data and protection outputs.
    always @(posedge core_clk) begin
        if (rst) begin
            lane_rx         <= 4'h0;
            serial_in_bit   <= 1'b0;
            write_protect_n <= 1'b1;
            write_accept    <= 1'b0;
            write_ignored   <= 1'b0;
            wr_cmd_r        <= 1'b0;
        end else begin
            // Raw lane levels for the data path, one cycle after synchronising.
            lane_rx       <= lane_sync;
            serial_in_bit <= lane_sync[0];
            // Sensing is registered so that write refusal sees a settled level;
            // the price is one extra cycle between a pin change and its effect.
            // Quad mode disables sensing; unarmed reads as not protected.
            if (wp_active(quad_enable_bit, status_write_disable_bit)) begin
                write_protect_n <= lane_sync[2];
            end else begin
                write_protect_n <= 1'b1;
            end
            wr_cmd_r <= status_register_write_cmd |
                        (any_register_write_cmd & write_targets_protected);
            // A protected write is silently refused; no error flag exists.
            // The refusal pulse marks only the first cycle of a held command.
            if (status_register_write_cmd ||
                (any_register_write_cmd && write_targets_protected)) begin
                write_accept  <= ~(status_write_disable_bit & ~write_protect_n);
                write_ignored <= ~wr_cmd_r & status_write_disable_bit & ~write_protect_n;
            end else begin
                write_accept  <= any_register_write_cmd;
                write_ignored <= 1'b0;
            end
        end
    end

    // Edge history, transfer type and deselect drive window.
    // Only a read leaves lane 3 with the device; after a write the host owns
    // it. The window opens on the synchronised rising edge of select.
    always @(posedge core_clk) begin
        if (rst) begin
            sclk_r     <= 1'b0;
            cs_r       <= 1'b1;
            was_read_r <= 1'b0;
            ds_cnt_r   <= 16'h0000;
        end else begin
            sclk_r <= sclk_sync;
            cs_r   <= cs_sync;
            if (!cs_sync) begin
                was_read_r <= read_transfer;
            end
            if (cs_sync && !cs_r && was_read_r) begin
                ds_cnt_r <= DESELECT_CYCLES[15:0];
            end else if (ds_cnt_r != 16'h0000) begin
                ds_cnt_r <= ds_cnt_r - 16'h0001;
            end
        end
    end

    // Reset detector: lane 3 low with select high for the pulse time.
    // The counter saturates one past the pulse point, so a long low gives a
    // single pulse and lane 3 must return high to arm the next one.
    // Limitation: a low shorter than the pulse time is never seen; the synchroniser
    // delays both of its edges alike, so the host must hold it for the full time.
    always @(posedge core_clk) begin
        if (rst) begin
            rp_cnt_r <= 16'h0000;
            hw_reset <= 1'b0;
        end else begin
            hw_reset <= 1'b0;
            if (rst_role(reset_pin_enable_bit, quad_enable_bit, cs_sync) &&
                cs_sync && !lane_sync[3] && ds_cnt_r == 16'h0000) begin
                if (rp_cnt_r == RESET_PULSE_CYCLES[15:0] - 16'h0001) begin
                    hw_reset <= 1'b1;
                end
                if (rp_cnt_r != RESET_PULSE_CYCLES[15:0]) begin
                    rp_cnt_r <= rp_cnt_r + 16'h0001;
                end
            end else begin
                // Any break in the condition restarts the count.
                rp_cnt_r <= 16'h0000;
            end
        end
    end

endmodule // pin_function_select

`default_nettype wire

// ### pin_function_select_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "pin_function_map.vh"

// Watches lane roles, write-protect sensing and the reset pulse.
module pfs_chk (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       quad_enable_bit,
    input wire logic       status_write_disable_bit,
    input wire logic       reset_pin_enable_bit,
    input wire logic [1:0] cmd_width,
    input wire logic       cs_n_level,
    input wire logic [3:0] lane_oe,
    input wire logic [3:0] lane_out,
    input wire logic       write_protect_n,
    input wire logic       write_ignored,
    input wire logic       hw_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // A detected reset shows for one cycle only.
    sequence s_pulse;
        hw_reset ##1 !hw_reset;
    endsequence
    a_lane0_single: assert property (
        cmd_width == `WIDTH_SINGLE |-> !lane_oe[0]) else $error("lane 0 driven in single width");
    a_lane2_data: assert property (
        lane_oe[2] |-> quad_enable_bit && cmd_width == `WIDTH_QUAD) else $error("lane 2 driven outside quad");
    a_lane3_select: assert property (
        lane_oe[3] && !cs_n_level |-> quad_enable_bit) else $error("lane 3 driven without quad");
    a_lane3_high: assert property (
        lane_oe[3] && cs_n_level |-> lane_out[3]) else $error("lane 3 low while deselected");
    a_wp_off: assert property (
        (quad_enable_bit || !status_write_disable_bit)
        && $past(quad_enable_bit || !status_write_disable_bit) |-> write_protect_n) else $error("write-protect sensed");
    a_reset_enable: assert property (
        hw_reset |-> $past(reset_pin_enable_bit)) else $error("reset while disabled");
    a_reset_deselect: assert property (
        hw_reset |-> $past(cs_n_level)) else $error("reset while selected");
    a_reset_lone: assert property (
        hw_reset |-> s_pulse) else $error("reset pulse too long");
    a_write_dropped: assert property (
        write_ignored |-> $past(status_write_disable_bit) && !$past(quad_enable_bit)) else $error("write dropped");
endmodule // pfs_chk

bind pin_function_select pfs_chk pfs_chk_i (.core_clk, .rst, .quad_enable_bit, .status_write_disable_bit,
    .reset_pin_enable_bit, .cmd_width, .cs_n_level, .lane_oe, .lane_out, .write_protect_n, .write_ignored, .hw_reset);
`default_nettype wire

// ### spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host controller: it always drives lanes 2 and 3 to a definite level.
module spi_host_model (
    output logic       cs_n,
    output logic       sclk,
    output logic [3:0] lane,
    output logic [3:0] oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        lane = 4'hF;
        oe = 4'hC;
    end
    // One frame; the link clock idles low between frames.
    // Every change lands on a core clock edge as a non-blocking update, so the
    // block never samples a pin in the same step in which it moves.
    task frame(input integer s, input integer n);
        cs_n <= 1'b0;
        oe   <= 4'hF;
        repeat (n) begin
            lane <= 4'($random(s));
            #80 sclk <= 1'b1;
            #80 sclk <= 1'b0;
        end
        lane <= 4'hF;
        cs_n <= 1'b1;
        oe   <= 4'hC;
    endtask
    // Lane 3 low for t ns while deselected.
    task rst_low(input integer t);
        lane[3] <= 1'b0;
        #t lane[3] <= 1'b1;
    endtask
    // Write-protect level, held until changed again.
    task wp(input logic v);
        lane[2] <= v;
    endtask
endmodule // spi_host_model
`default_nettype wire

// ### pin_function_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pin_function_map.vh"

// Host model drives the pins; pulses are matched against a queue.
module pin_function_select_tb_top;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       q, swd, ren, rd, srw, arw, tgt, flip, cs_n, sclk, wpn, wa, wi, hr, sib, rise, csl;
    logic [1:0] w;
    logic [3:0] cout, cdrv, lo, loe, hl, hoe, pins, rx;
    logic [1:0] exp_q[$];
    integer     fails = 0, compares = 0, cyc = 0, seed = 51350;
    integer     rises = 0, held = 0; // Seen clock edges and deselect drive cycles.
    always #5 core_clk = ~core_clk;
    // Undriven lanes 2 and 3 are pulled up; lanes 0 and 1 wander.
    assign pins = (loe & lo) | (~loe & hoe & hl) | (~loe & ~hoe & {2'b11, flip, ~flip});
    pin_function_select #(.RESET_PULSE_CYCLES(4)) pin_function_select_i (.core_clk(core_clk), .rst(rst),
        .quad_enable_bit(q), .status_write_disable_bit(swd), .reset_pin_enable_bit(ren), .cmd_width(w),
        .read_transfer(rd), .status_register_write_cmd(srw), .any_register_write_cmd(arw),
        .write_targets_protected(tgt), .cs_n_pin(cs_n), .sclk_pin(sclk), .lane_in(pins), .core_lane_out(cout),
        .core_lane_drive(cdrv), .lane_out(lo), .lane_oe(loe), .lane_rx(rx), .serial_in_bit(sib),
        .write_protect_n(wpn), .write_accept(wa), .write_ignored(wi), .hw_reset(hr), .sclk_rise(rise),
        .cs_n_level(csl));
    spi_host_model spi_host_model_i (.cs_n(cs_n), .sclk(sclk), .lane(hl), .oe(hoe));
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task cfg(input logic [2:0] v);
        @(posedge core_clk);
        {q, swd, ren} <= v;
        repeat (8) @(posedge core_clk);
    endtask
    // Every pulse takes the oldest note; an unplanned pulse meets zero.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        flip <= ~flip;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
        if (!rst && (hr || wi))
            check("pulse", {14'h0000, hr, wi}, exp_q.size() ? {14'h0000, exp_q.pop_front()} : 16'h0000);
        // Every rising serial clock edge is counted; single width samples lane 0 there.
        if (!rst && rise) rises <= rises + 1;
        if (!rst && rise && w == `WIDTH_SINGLE) check("serial_in", {15'h0000, sib}, {15'h0000, hl[0]});
        // Cycles in which the device holds lane 3 while deselected.
        if (!rst && loe[3] && csl) held <= held + 1;
    end
    initial begin
        {q, swd, ren, rd, srw, arw, flip, w, cout, cdrv} = 0;
        tgt = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        // Long and short lows on lane 3, reset on and off, quad on and off.
        for (int k = 0; k < 8; k++) begin
            cfg({k[0], 1'b0, k[1]});
            if (k[1] && k[2]) exp_q.push_back(2'b10);
            spi_host_model_i.rst_low(k[2] ? 200 : 20);
            repeat (12) @(posedge core_clk);
        end
        // Frames of every width; lane 3 data while selected is no reset.
        cfg(3'b101);
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            w <= k[1:0];
            rd <= k[1];
            cdrv <= 4'hF;
            cout <= 4'($random(seed));
            spi_host_model_i.frame($random(seed), 30);
            repeat (12) @(posedge core_clk);
            check("rises", 16'(rises), 16'(30 * (k + 1)));
            check("lane_rx", {14'h0000, rx[3:2]}, 16'h0003);
            check("cs_level", {15'h0000, csl}, 16'h0001);
        end
        // Only the one read frame leaves lane 3 with the device.
        check("deselect", 16'(held), 16'(`DESELECT_CYCLES));
        // Protected writes drop only while write-protect is sensed low.
        for (int k = 0; k < 8; k++) begin
            cfg({k[0], 2'b10});
            spi_host_model_i.wp(k[1]);
            repeat (8) @(posedge core_clk);
            if (!k[0] && !k[1]) exp_q.push_back(2'b01);
            srw <= k[2];
            arw <= !k[2];
            repeat (4) @(posedge core_clk);
            check("accept", {15'h0000, wa}, {15'h0000, k[0] | k[1]});
            check("wp_n", {15'h0000, wpn}, {15'h0000, k[0] | k[1]});
            srw <= 1'b0;
            arw <= 1'b0;
        end
        check("queue", 16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule // pin_function_select_tb_top
`default_nettype wire
